// ---- ffs_params.svh ----
// constants of the fifo frame sync register bank: offsets, field positions, reset values, counts
// assumes inclusion by bare name from every design file that needs a number
`ifndef FFS_PARAMS_SVH
`define FFS_PARAMS_SVH

// register offsets on the serial port
`define FFS_ADDR_PART_ID      7'h1f
`define FFS_ADDR_IRQ_SEL      7'h20
`define FFS_ADDR_ALIGN_CTRL   7'h21
`define FFS_ADDR_FRAME_CTRL   7'h22
`define FFS_ADDR_DEPTH_REQ    7'h23
`define FFS_ADDR_DEPTH_MEAS   7'h24

// reset values
`define FFS_RST_IRQ_SEL       8'h00
`define FFS_RST_ALIGN_CTRL    8'h00
`define FFS_RST_FRAME_CTRL    8'h12
`define FFS_RST_DEPTH_REQ     8'h40
`define FFS_RST_DEPTH_MEAS    8'h00

// identification value, arbitrary
`define FFS_PART_ID_VALUE     8'h5c

// interrupt operating mode codes
`define FFS_IRQ_TEST_MODE     8'h00
`define FFS_IRQ_NORMAL_MODE   8'h01

// field positions
`define FFS_BIT_ALIGN_EN      0
`define FFS_BIT_ALIGN_EDGE    1
`define FFS_BIT_FRAME_REPEAT  2
`define FFS_BIT_FRAME_REARM   3
`define FFS_LSB_FRAME_TARGET  0
`define FFS_MSB_FRAME_TARGET  1
`define FFS_LSB_WHOLE         4
`define FFS_MSB_WHOLE         6
`define FFS_LSB_SUB           0
`define FFS_MSB_SUB           2

// serial frame layout
`define FFS_SP_READ_BIT       7
`define FFS_SP_LAST_BIT       4'd7

// cycles from a fifo reset until the measured depth is captured
`define FFS_SETTLE_CYCLES     4'd8

`endif

// ---- ffs_pkg.sv ----
// types shared by the fifo frame sync register bank and its serial port
// assumes nothing of its surroundings
package ffs_pkg;

	// one register write from the serial port
	typedef struct packed {
		logic [6:0] addr;
		logic [7:0] data;
	} ffs_wr_t;

	// fifo depth: whole input samples and converter clock steps
	typedef struct packed {
		logic [2:0] whole;
		logic [2:0] sub;
	} ffs_depth_t;

	// what a valid frame pulse resets, in field-code order
	typedef enum logic [1:0] {
		FFS_TGT_FIFO,
		FFS_TGT_OSC,
		FFS_TGT_BOTH,
		FFS_TGT_NONE
	} ffs_target_t;

	// serial port frame phases
	typedef enum logic [1:0] {
		FFS_SP_INSTR,
		FFS_SP_WDATA,
		FFS_SP_RDATA,
		FFS_SP_DONE
	} ffs_sp_state_t;

endpackage

// ---- ffs_serial_port.sv ----
// three-wire serial port slave: instruction byte (read flag, 7-bit address), one data byte
// assumes sclk, csb_n and sdio come from pins, asynchronous to clk and much slower than it
`timescale 1ns/1ps
`include "ffs_params.svh"

module ffs_serial_port (
	// clock and reset
	input  wire logic           clk,
	input  wire logic           rst,
	// serial pins
	input  wire logic           sclk,
	input  wire logic           csb_n,
	input  wire logic           sdio_in,
	output logic                sdio_out,
	output logic                sdio_oe_n,
	// register side
	output ffs_pkg::ffs_wr_t    wr_req,
	output logic                wr_valid,
	output logic [6:0]          rd_addr,
	output logic                rd_load,
	input  wire logic [7:0]     rd_data
);

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: bit 0 sclk, bit 1 csb_n, bit 2 sdio

	localparam logic [2:0] PIN_IDLE = 3'h2; // csb_n idles high

	logic [2:0] pin_raw;
	logic [2:0] pin_s1;
	logic [2:0] pin_s2;
	logic [2:0] pin_s3;
	logic [2:0] pin_f;
	logic [2:0] next_pin_f;

	assign pin_raw = {sdio_in, csb_n, sclk};

	// a pin change counts only once the second and third stage agree
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_filt
			always_comb begin
				next_pin_f[gi] = (pin_s2[gi] == pin_s3[gi]) ? pin_s3[gi] : pin_f[gi];
			end
		end
	endgenerate

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_s1 <= PIN_IDLE;
			pin_s2 <= PIN_IDLE;
			pin_s3 <= PIN_IDLE;
			pin_f  <= PIN_IDLE;
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_f  <= next_pin_f;
		end
	end

	logic sclk_rise;
	logic sclk_fall;
	logic sel_n;

	// edges from the filtered level only
	assign sclk_rise = next_pin_f[0] & ~pin_f[0];
	assign sclk_fall = ~next_pin_f[0] & pin_f[0];
	assign sel_n     = pin_f[1];

	////////////////////////////////////////////////////////////////////////////////
	// frame sequencer

	ffs_pkg::ffs_sp_state_t state;
	ffs_pkg::ffs_sp_state_t next_state;
	logic [3:0]             bit_cnt;
	logic [3:0]             next_bit_cnt;
	logic [7:0]             rx_shift;
	logic [7:0]             next_rx_shift;
	logic [7:0]             tx_shift;
	logic [7:0]             next_tx_shift;
	logic [6:0]             addr;
	logic [6:0]             next_addr;
	logic                   next_sdio_out;
	logic                   next_sdio_oe_n;
	logic                   next_wr_valid;

	// next frame state; csb_n high aborts any half-done frame
	always_comb begin
		next_state     = state;
		next_bit_cnt   = bit_cnt;
		next_rx_shift  = rx_shift;
		next_tx_shift  = tx_shift;
		next_addr      = addr;
		next_sdio_out  = sdio_out;
		next_sdio_oe_n = sdio_oe_n;
		next_wr_valid  = 1'b0;
		rd_load        = 1'b0;
		if (sel_n) begin
			next_state     = ffs_pkg::FFS_SP_INSTR;
			next_bit_cnt   = 4'h0;
			next_sdio_oe_n = 1'b1;
		end else begin
			unique case (state)
				ffs_pkg::FFS_SP_INSTR: begin
					if (sclk_rise) begin
						next_rx_shift = {rx_shift[6:0], pin_f[2]};
						next_bit_cnt  = bit_cnt + 4'h1;
						if (bit_cnt == `FFS_SP_LAST_BIT) begin
							next_bit_cnt = 4'h0;
							next_addr    = {rx_shift[5:0], pin_f[2]};
							if (rx_shift[`FFS_SP_READ_BIT - 1]) begin
								// fetch now so the first bit is ready at the next falling edge
								rd_load       = 1'b1;
								next_tx_shift = rd_data;
								next_state    = ffs_pkg::FFS_SP_RDATA;
							end else begin
								next_state = ffs_pkg::FFS_SP_WDATA;
							end
						end
					end
				end
				ffs_pkg::FFS_SP_WDATA: begin
					if (sclk_rise) begin
						next_rx_shift = {rx_shift[6:0], pin_f[2]};
						next_bit_cnt  = bit_cnt + 4'h1;
						if (bit_cnt == `FFS_SP_LAST_BIT) begin
							next_wr_valid = 1'b1;
							next_state    = ffs_pkg::FFS_SP_DONE;
						end
					end
				end
				ffs_pkg::FFS_SP_RDATA: begin
					if (sclk_fall) begin
						next_sdio_out  = tx_shift[7];
						next_tx_shift  = {tx_shift[6:0], 1'b0};
						next_sdio_oe_n = 1'b0;
					end
					if (sclk_rise) begin
						next_bit_cnt = bit_cnt + 4'h1;
						if (bit_cnt == `FFS_SP_LAST_BIT) begin
							next_state = ffs_pkg::FFS_SP_DONE;
						end
					end
				end
				ffs_pkg::FFS_SP_DONE: begin
					// extra clocks are ignored; release the line after the last bit
					if (sclk_fall) begin
						next_sdio_oe_n = 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state     <= ffs_pkg::FFS_SP_INSTR;
			bit_cnt   <= 4'h0;
			rx_shift  <= 8'h00;
			tx_shift  <= 8'h00;
			addr      <= 7'h00;
			sdio_out  <= 1'b0;
			sdio_oe_n <= 1'b1;
			wr_valid  <= 1'b0;
		end else begin
			state     <= next_state;
			bit_cnt   <= next_bit_cnt;
			rx_shift  <= next_rx_shift;
			tx_shift  <= next_tx_shift;
			addr      <= next_addr;
			sdio_out  <= next_sdio_out;
			sdio_oe_n <= next_sdio_oe_n;
			wr_valid  <= next_wr_valid;
		end
	end

	assign rd_addr     = next_addr;
	assign wr_req.addr = addr;
	assign wr_req.data = rx_shift;

endmodule

// ---- ffs_regs.sv ----
// fifo frame sync register bank: identification, interrupt mode, multichip alignment,
// frame pulse resets and fifo depth request and readback
// assumes: clk is the converter clock; frame and alignment pins are asynchronous;
// the measured depth comes from the fifo datapath on clk
//
// Summary of operation
// - fixed read-only eight-bit identifier; writes are ignored
// - interrupt mode register: 0x00 test mode, 0x01 normal recommended mode
// - edge select picks falling or rising sampling of alignment clock; bit 0 enables
// - one-shot mode: writing the rearm bit makes the next valid pulse act
// - repeat bit 0: act on first valid pulse only, reset the selected target once
// - repeat bit 1: every valid frame pulse resets the selected target
// - target field: fifo, oscillator, both or nothing; reset value 0x2
// - whole-sample depth request, bits 6:4, resets to 4
// - sub-sample depth request bits 2:0; software keeps it below interpolation factor
// - measured depth readable as whole bits 6:4 and sub bits 2:0
`timescale 1ns/1ps
`include "ffs_params.svh"

module ffs_regs (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// serial port pins
	input  wire logic              sclk,
	input  wire logic              csb_n,
	input  wire logic              sdio_in,
	output logic                   sdio_out,
	output logic                   sdio_oe_n,
	// frame and alignment pins
	input  wire logic              frame_pin,
	input  wire logic              align_ref_pin,
	// fifo datapath
	input  ffs_pkg::ffs_depth_t    depth_measured,
	output ffs_pkg::ffs_depth_t    depth_request,
	output logic                   fifo_reset,
	output logic                   osc_reset,
	// alignment and interrupt mode
	output logic                   align_enable,
	output logic                   align_ref_level,
	output logic [7:0]             irq_mode,
	output logic                   irq_normal_mode
);

	////////////////////////////////////////////////////////////////////////////////
	// serial port

	ffs_pkg::ffs_wr_t wr_req;
	logic             wr_valid;
	logic [6:0]       rd_addr;
	logic             rd_load;
	logic [7:0]       rd_data;

	ffs_serial_port u_port (
		.clk       (clk),
		.rst       (rst),
		.sclk      (sclk),
		.csb_n     (csb_n),
		.sdio_in   (sdio_in),
		.sdio_out  (sdio_out),
		.sdio_oe_n (sdio_oe_n),
		.wr_req    (wr_req),
		.wr_valid  (wr_valid),
		.rd_addr   (rd_addr),
		.rd_load   (rd_load),
		.rd_data   (rd_data)
	);

	// address match, shared by write decode and read mux
	function automatic logic addr_hit(input logic [6:0] a, input logic [6:0] ref_addr);
		addr_hit = (a == ref_addr);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// software registers

	logic [7:0] irq_operating_select;
	logic [7:0] multichip_align_control;
	logic [7:0] frame_pulse_reset_control;
	logic [7:0] buffer_depth_request;
	logic [7:0] next_irq_operating_select;
	logic [7:0] next_multichip_align_control;
	logic [7:0] next_frame_pulse_reset_control;
	logic [7:0] next_buffer_depth_request;
	logic       rearm_write;

	// write decode; the identifier and readback have no write path
	always_comb begin
		next_irq_operating_select      = irq_operating_select;
		next_multichip_align_control   = multichip_align_control;
		next_frame_pulse_reset_control = frame_pulse_reset_control;
		next_buffer_depth_request      = buffer_depth_request;
		rearm_write                    = 1'b0;
		if (wr_valid) begin
			if (addr_hit(wr_req.addr, `FFS_ADDR_IRQ_SEL)) begin
				next_irq_operating_select = wr_req.data;
			end
			if (addr_hit(wr_req.addr, `FFS_ADDR_ALIGN_CTRL)) begin
				next_multichip_align_control = wr_req.data;
			end
			if (addr_hit(wr_req.addr, `FFS_ADDR_FRAME_CTRL)) begin
				next_frame_pulse_reset_control = wr_req.data;
				rearm_write                    = wr_req.data[`FFS_BIT_FRAME_REARM];
			end
			if (addr_hit(wr_req.addr, `FFS_ADDR_DEPTH_REQ)) begin
				next_buffer_depth_request = wr_req.data;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_operating_select      <= `FFS_RST_IRQ_SEL;
			multichip_align_control   <= `FFS_RST_ALIGN_CTRL;
			frame_pulse_reset_control <= `FFS_RST_FRAME_CTRL;
			buffer_depth_request      <= `FFS_RST_DEPTH_REQ;
		end else begin
			irq_operating_select      <= next_irq_operating_select;
			multichip_align_control   <= next_multichip_align_control;
			frame_pulse_reset_control <= next_frame_pulse_reset_control;
			buffer_depth_request      <= next_buffer_depth_request;
		end
	end

	// register fields toward the datapath
	assign irq_mode            = irq_operating_select;
	assign irq_normal_mode     = (irq_operating_select == `FFS_IRQ_NORMAL_MODE);
	assign align_enable        = multichip_align_control[`FFS_BIT_ALIGN_EN];
	assign depth_request.whole = buffer_depth_request[`FFS_MSB_WHOLE:`FFS_LSB_WHOLE];
	assign depth_request.sub   = buffer_depth_request[`FFS_MSB_SUB:`FFS_LSB_SUB];

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers on the rising edge: bit 0 frame, bit 1 alignment clock

	logic [1:0] pin_s1;
	logic [1:0] pin_s2;
	logic [1:0] pin_s3;
	logic [1:0] pin_f;
	logic [1:0] next_pin_f;

	// change accepted once the second and third stage agree
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_filt
			always_comb begin
				next_pin_f[gi] = (pin_s2[gi] == pin_s3[gi]) ? pin_s3[gi] : pin_f[gi];
			end
		end
	endgenerate

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_s1 <= 2'h0;
			pin_s2 <= 2'h0;
			pin_s3 <= 2'h0;
			pin_f  <= 2'h0;
		end else begin
			pin_s1 <= {align_ref_pin, frame_pin};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_f  <= next_pin_f;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// alignment clock sampled on the falling edge; own chain so the two edges never mix

	logic neg_s1;
	logic neg_s2;
	logic neg_s3;
	logic neg_f;
	logic next_neg_f;
	logic next_align_level;

	always_ff @(negedge clk or posedge rst) begin
		if (rst) begin
			neg_s1 <= 1'b0;
		end else begin
			neg_s1 <= align_ref_pin;
		end
	end

	// edge select chooses which capture feeds the aligner; disabled alignment reads low
	always_comb begin
		next_neg_f       = (neg_s2 == neg_s3) ? neg_s3 : neg_f;
		next_align_level = 1'b0;
		if (multichip_align_control[`FFS_BIT_ALIGN_EN]) begin
			next_align_level = multichip_align_control[`FFS_BIT_ALIGN_EDGE] ?
				pin_f[1] : neg_f;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			neg_s2          <= 1'b0;
			neg_s3          <= 1'b0;
			neg_f           <= 1'b0;
			align_ref_level <= 1'b0;
		end else begin
			neg_s2          <= neg_s1;
			neg_s3          <= neg_s2;
			neg_f           <= next_neg_f;
			align_ref_level <= next_align_level;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// frame pulse resets

	logic                  frame_prev;
	logic                  frame_valid;
	logic                  armed;
	logic                  next_armed;
	logic                  act;
	logic                  next_fifo_reset;
	logic                  next_osc_reset;
	ffs_pkg::ffs_target_t  target;

	assign frame_valid = pin_f[0] & ~frame_prev;
	assign target      = ffs_pkg::ffs_target_t'(
		frame_pulse_reset_control[`FFS_MSB_FRAME_TARGET:`FFS_LSB_FRAME_TARGET]);

	// one-shot consumes the arm; a rearm write in the same cycle wins over the consume
	always_comb begin
		act        = frame_valid &
			(frame_pulse_reset_control[`FFS_BIT_FRAME_REPEAT] | armed);
		next_armed = armed;
		if (act) begin
			next_armed = 1'b0;
		end
		if (rearm_write) begin
			next_armed = 1'b1;
		end
		next_fifo_reset = 1'b0;
		next_osc_reset  = 1'b0;
		if (act) begin
			unique case (target)
				ffs_pkg::FFS_TGT_FIFO: next_fifo_reset = 1'b1;
				ffs_pkg::FFS_TGT_OSC:  next_osc_reset  = 1'b1;
				ffs_pkg::FFS_TGT_BOTH: begin
					next_fifo_reset = 1'b1;
					next_osc_reset  = 1'b1;
				end
				ffs_pkg::FFS_TGT_NONE: begin
					next_fifo_reset = 1'b0;
				end
			endcase
		end
	end

	// armed from reset so the first valid pulse after power-up acts
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			frame_prev <= 1'b0;
			armed      <= 1'b1;
			fifo_reset <= 1'b0;
			osc_reset  <= 1'b0;
		end else begin
			frame_prev <= pin_f[0];
			armed      <= next_armed;
			fifo_reset <= next_fifo_reset;
			osc_reset  <= next_osc_reset;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// measured depth capture, a fixed settle time after each fifo reset

	logic [3:0] settle_cnt;
	logic [3:0] next_settle_cnt;
	logic [7:0] buffer_depth_measured;
	logic [7:0] next_buffer_depth_measured;

	// a fresh reset during the wait restarts it, so the capture follows the last one
	always_comb begin
		next_settle_cnt            = settle_cnt;
		next_buffer_depth_measured = buffer_depth_measured;
		if (fifo_reset) begin
			next_settle_cnt = `FFS_SETTLE_CYCLES;
		end else if (settle_cnt != 4'h0) begin
			next_settle_cnt = settle_cnt - 4'h1;
			if (settle_cnt == 4'h1) begin
				next_buffer_depth_measured =
					{1'b0, depth_measured.whole, 1'b0, depth_measured.sub};
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			settle_cnt            <= 4'h0;
			buffer_depth_measured <= `FFS_RST_DEPTH_MEAS;
		end else begin
			settle_cnt            <= next_settle_cnt;
			buffer_depth_measured <= next_buffer_depth_measured;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read mux; unmapped addresses read zero

	always_comb begin
		rd_data = 8'h00;
		if (rd_load) begin
			if (addr_hit(rd_addr, `FFS_ADDR_PART_ID)) begin
				rd_data = `FFS_PART_ID_VALUE;
			end
			if (addr_hit(rd_addr, `FFS_ADDR_IRQ_SEL)) begin
				rd_data = irq_operating_select;
			end
			if (addr_hit(rd_addr, `FFS_ADDR_ALIGN_CTRL)) begin
				rd_data = multichip_align_control;
			end
			if (addr_hit(rd_addr, `FFS_ADDR_FRAME_CTRL)) begin
				rd_data = frame_pulse_reset_control;
			end
			if (addr_hit(rd_addr, `FFS_ADDR_DEPTH_REQ)) begin
				rd_data = buffer_depth_request;
			end
			if (addr_hit(rd_addr, `FFS_ADDR_DEPTH_MEAS)) begin
				rd_data = buffer_depth_measured;
			end
		end
	end

endmodule

// ---- ffs_regs_checker.sv ----
// concurrent checks on the ports of the fifo frame sync register bank
// assumes one clock domain, clk, with rst asynchronous and active high
`timescale 1ns/1ps

module ffs_regs_checker (
	// clock and reset
	input  wire logic          clk,
	input  wire logic          rst,
	// pins
	input  wire logic          csb_n,
	input  wire logic          sdio_oe_n,
	input  wire logic          frame_pin,
	input  wire logic          align_ref_pin,
	// outputs under watch
	input  ffs_pkg::ffs_depth_t depth_request,
	input  wire logic          fifo_reset,
	input  wire logic          osc_reset,
	input  wire logic          align_enable,
	input  wire logic          align_ref_level,
	input  wire logic [7:0]    irq_mode,
	input  wire logic          irq_normal_mode
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////////////
	// cycles since the frame pin last rose, saturating so a stray pulse is caught
	logic [3:0] since_rise;
	logic [3:0] next_since_rise;
	logic       pin_q;
	logic       next_pin_q;

	always_comb begin
		next_pin_q = frame_pin;
		next_since_rise = since_rise;
		if (frame_pin && !pin_q) begin
			next_since_rise = 4'h0;
		end else if (since_rise != 4'hf) begin
			next_since_rise = since_rise + 4'h1;
		end
	end

	// pin_q starts high so a pin already high at release is not a rise
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			since_rise <= 4'hf;
			pin_q <= 1'b1;
		end else begin
			since_rise <= next_since_rise;
			pin_q <= next_pin_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// serial port idle and alignment reference held
	sequence port_idle;
		csb_n [*8];
	endsequence

	sequence ref_held_high;
		(align_enable && align_ref_pin) [*8];
	endsequence

	fifo_pulse_a: assert property (fifo_reset |=> !fifo_reset [*3])
		else $error("fifo reset longer than one cycle");
	osc_pulse_a: assert property (osc_reset |=> !osc_reset [*3])
		else $error("oscillator reset longer than one cycle");
	pulse_cause_a: assert property ((fifo_reset || osc_reset) |->
		since_rise inside {[4'h1:4'ha]})
		else $error("frame reset without a recent frame pulse");
	irq_decode_a: assert property ($stable(irq_mode) |->
		irq_normal_mode == (irq_mode == 8'h01))
		else $error("normal interrupt mode flag disagrees with mode value");
	port_release_a: assert property (port_idle |-> sdio_oe_n)
		else $error("data pin driven while deselected");
	idle_stable_a: assert property (port_idle |=>
		$stable({depth_request, irq_mode, align_enable}))
		else $error("register output changed with no serial frame");
	align_high_a: assert property (ref_held_high |-> align_ref_level)
		else $error("alignment level not following high reference");
	align_low_a: assert property ((!align_ref_pin) [*8] |-> !align_ref_level)
		else $error("alignment level not following low reference");
	align_gate_a: assert property (align_ref_level |-> (align_enable || $past(align_enable)))
		else $error("alignment level high while alignment disabled");
endmodule

bind ffs_regs ffs_regs_checker ffs_regs_checker_i (
	.clk(clk), .rst(rst), .csb_n(csb_n), .sdio_oe_n(sdio_oe_n), .frame_pin(frame_pin),
	.align_ref_pin(align_ref_pin), .depth_request(depth_request), .fifo_reset(fifo_reset),
	.osc_reset(osc_reset), .align_enable(align_enable), .align_ref_level(align_ref_level),
	.irq_mode(irq_mode), .irq_normal_mode(irq_normal_mode)
);

// ---- tb.sv ----
// self-checking bench for the fifo frame sync register bank
// assumes the bench bit-bangs the serial pins and resolves the shared data wire
`timescale 1ns/1ps

module tb;
	logic                clk, rst, sclk, csb_n, tb_sdio, sdio_wire, frame_pin, align_ref_pin;
	logic                sdio_out, sdio_oe_n, fifo_reset, osc_reset, seen_f, seen_o;
	logic                align_enable, align_ref_level, irq_normal_mode;
	logic [7:0]          irq_mode, rd;
	ffs_pkg::ffs_depth_t depth_measured, depth_request;
	int                  err_count, compares;
	// register rows: address, written value, value read back
	logic [6:0] t_a [8] = '{7'h20, 7'h20, 7'h21, 7'h23, 7'h23, 7'h1f, 7'h24, 7'h30};
	logic [7:0] t_w [8] = '{8'h00, 8'h01, 8'h03, 8'h40, 8'h75, 8'ha5, 8'hff, 8'h77};
	logic [7:0] t_e [8] = '{8'h00, 8'h01, 8'h03, 8'h40, 8'h75, 8'h5c, 8'h00, 8'h00};
	logic [6:0] r_a [6] = '{7'h1f, 7'h20, 7'h21, 7'h22, 7'h23, 7'h24};
	logic [7:0] r_e [6] = '{8'h5c, 8'h00, 8'h00, 8'h12, 8'h40, 8'h00};
	logic [7:0] ac [3] = '{8'h01, 8'h03, 8'h00};
	// frame rows: control write (ff for none), expected fifo and oscillator resets
	logic [7:0] pw [9] = '{8'hff, 8'hff, 8'h08, 8'hff, 8'h09, 8'h0b, 8'h02, 8'h06, 8'hff};
	logic [8:0] pf = 9'h185;
	logic [8:0] po = 9'h191;

	// released wire shows a changing pattern from the bench, never a stale value
	assign sdio_wire = sdio_oe_n ? tb_sdio : sdio_out;

	ffs_regs ffs_regs_i (
		.clk(clk), .rst(rst), .sclk(sclk), .csb_n(csb_n), .sdio_in(sdio_wire),
		.sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .frame_pin(frame_pin),
		.align_ref_pin(align_ref_pin), .depth_measured(depth_measured),
		.depth_request(depth_request), .fifo_reset(fifo_reset), .osc_reset(osc_reset),
		.align_enable(align_enable), .align_ref_level(align_ref_level), .irq_mode(irq_mode),
		.irq_normal_mode(irq_normal_mode)
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// verdict and comparison
	task summarize;
		if (err_count == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task wait_clk(input int n);
		repeat (n) @(negedge clk);
	endtask

	task do_reset;
		rst = 1'b1;
		wait_clk(16);
		rst = 1'b0;
		wait_clk(6);
	endtask

	// one serial frame, 10 clocks per sclk phase; nbits below 16 aborts it
	task sp(input logic rf, input logic [6:0] addr, input logic [7:0] wd, input int nbits);
		logic [15:0] frame;
		frame = {rf, addr, wd};
		csb_n = 1'b0;
		wait_clk(10);
		for (int i = 15; i > 15 - nbits; i--) begin
			sclk = 1'b0;
			tb_sdio = (rf && i < 8) ? ~tb_sdio : frame[i];
			wait_clk(10);
			sclk = 1'b1;
			if (i < 8) rd[i] = sdio_wire;
			wait_clk(10);
		end
		csb_n = 1'b1;
		sclk = 1'b0;
		wait_clk(10);
	endtask

	// frame pulse 13 clocks high, 11 low; resets are one-cycle so sampled every cycle
	task pulse;
		seen_f = 1'b0;
		seen_o = 1'b0;
		frame_pin = 1'b1;
		for (int k = 0; k < 24; k++) begin
			@(negedge clk);
			if (k == 12) frame_pin = 1'b0;
			seen_f |= (fifo_reset === 1'b1);
			seen_o |= (osc_reset === 1'b1);
		end
	endtask

	initial begin
		#2000000;
		err_count++;
		summarize;
	end

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		rst = 1'b1;
		sclk = 1'b0;
		csb_n = 1'b1;
		tb_sdio = 1'b0;
		frame_pin = 1'b0;
		align_ref_pin = 1'b0;
		depth_measured = 6'h00;
		err_count = 0;
		compares = 0;
		do_reset;
		for (int r = 0; r < 8; r++) begin
			sp(1'b0, t_a[r], t_w[r], 16);
			sp(1'b1, t_a[r], 8'h00, 16);
			chk("readback", rd, t_e[r]);
		end
		chk("irq_mode", irq_mode, 8'h01);
		chk("irq_normal_mode", {7'h00, irq_normal_mode}, 8'h01);
		chk("depth_request", {2'h0, depth_request}, 8'h3d);
		chk("align_enable", {7'h00, align_enable}, 8'h01);
		for (int r = 0; r < 3; r++) begin
			sp(1'b0, 7'h21, ac[r], 16);
			align_ref_pin = 1'b1;
			wait_clk(12);
			chk("align_high", {7'h00, align_ref_level}, {7'h00, ac[r][0]});
			align_ref_pin = 1'b0;
			wait_clk(12);
			chk("align_low", {7'h00, align_ref_level}, 8'h00);
		end
		// second reset in mid-run brings back every reset value
		do_reset;
		for (int r = 0; r < 6; r++) begin
			sp(1'b1, r_a[r], 8'h00, 16);
			chk("reset_value", rd, r_e[r]);
		end
		chk("depth_request_rst", {2'h0, depth_request}, 8'h20);
		chk("irq_normal_rst", {7'h00, irq_normal_mode}, 8'h00);
		sp(1'b0, 7'h23, 8'h11, 12);
		sp(1'b1, 7'h23, 8'h00, 16);
		chk("aborted_write", rd, 8'h40);
		for (int r = 0; r < 9; r++) begin
			if (r == 8) depth_measured = 6'h2b;
			if (pw[r] != 8'hff) sp(1'b0, 7'h22, pw[r], 16);
			pulse;
			chk("fifo_reset", {7'h00, seen_f}, {7'h00, pf[r]});
			chk("osc_reset", {7'h00, seen_o}, {7'h00, po[r]});
		end
		sp(1'b1, 7'h24, 8'h00, 16);
		chk("depth_measured", rd, 8'h53);
		// no reset since, so a new fifo distance must not show
		depth_measured = 6'h07;
		wait_clk(20);
		sp(1'b1, 7'h24, 8'h00, 16);
		chk("depth_hold", rd, 8'h53);
		summarize;
	end
endmodule
